// ===== verilog/cpuxe_core.sv
// Execution unit for zero test, exclusive-OR and extended pointer instructions
`timescale 1ns/100ps
`default_nettype none
`include "cpuxe_params.svh"
module cpuxe_core
  import cpuxe_pkg::*;
#(
  parameter int STACK_DEPTH = 31
)
(
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        extensionEnableCfg,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest
);
  localparam int SPW = $clog2(STACK_DEPTH + 1);

  cpuxe_state_e   state;
  cpuxe_op_e      op;
  cpuxe_op_e      next_op;
  logic [15:0]    ir;
  logic [15:0]    firstWord;
  logic           firstPending;
  logic           skipPending;
  logic           skipSecond;
  logic [7:0]     acc;
  logic [7:0]     bank;
  logic [7:0]     highLatch;
  logic [4:0]     upperLatch;
  logic [7:0]     tabLatch;
  logic           flagN;
  logic           flagZ;
  logic [11:0]    ptr [3];
  logic [20:0]    pc;
  logic [20:0]    table_pointer;
  logic [11:0]    memAddr;
  logic [7:0]     mem [`CPUXE_MEM_WORDS];
  logic [7:0]     hold [8];
  logic [20:0]    stack [STACK_DEPTH];
  logic [SPW-1:0] sp;
  logic [31:0]    cycleCount;
  logic [3:0]     clkCount;
  logic           cfgSync1;
  logic           cfgSync2;
  logic           extEn;
  logic           rdValid;
  logic [31:0]    rdMux;
  logic           busWr;
  logic           done;
  logic [15:0]    w;
  logic [7:0]     fileOfs;
  logic [11:0]    fileAddr;
  logic [7:0]     fileVal;
  logic [7:0]     xorRes;
  logic [11:0]    moveSrc;
  logic [11:0]    moveDst;
  logic           memWe;
  logic [11:0]    memWa;
  logic [7:0]     memWd;
  logic [1:0]     ptrSel;
  logic [11:0]    ptrNew;
  logic           isRet;
  logic [20:0]    tblNext;
  logic [20:0]    tblUse;

  // Byte-lane merge of a bus write into an old value
  function automatic logic [31:0] merge(input logic [31:0] old);
    logic [31:0] m;
    m = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
    merge = (old & ~m) | (writedata & m);
  endfunction

  assign w     = writedata[15:0];
  assign busWr = write && (state == ST_IDLE) && (address != `CPUXE_OFS_INSTR);
  assign done  = (state == ST_DONE);
  assign isRet = (op == OP_PADDRET) || (op == OP_PSUBRET);

  // Configuration pin synchroniser and capture at reset
  always_ff @(posedge ref_clk)
  begin
    cfgSync1 <= extensionEnableCfg;
    cfgSync2 <= cfgSync1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      extEn <= cfgSync2;
  end

  // Decode of the issued word
  always_comb
  begin
    next_op = OP_NOP;
    if (skipPending || skipSecond)
      next_op = OP_NOP;
    else if (firstPending && (w[15:12] == 4'hF))
      next_op = firstWord[7] ? OP_MOVE_TO_OFS : OP_MOVE_TO_FILE;
    else if (extEn && (w[15:8] == 8'hE8))
      next_op = (w[7:6] == 2'b11) ? OP_PADDRET : OP_PADD;
    else if (extEn && (w[15:8] == 8'hE9))
      next_op = (w[7:6] == 2'b11) ? OP_PSUBRET : OP_PSUB;
    else if (extEn && (w[15:8] == 8'hEB) && !w[7])
      next_op = OP_FIRST;
    else if (extEn && (w[15:8] == 8'hEB))
      next_op = OP_FIRST;
    else if (extEn && (w[15:8] == 8'hEA))
      next_op = OP_LIT_PUSH;
    else if (extEn && (w == `CPUXE_CALL_ACC_CODE))
      next_op = OP_CALL_ACC;
    else if (w[15:9] == 7'b0110011)
      next_op = OP_ZTEST;
    else if (w[15:8] == 8'h0A)
      next_op = OP_XORI;
    else if (w[15:10] == 6'b000110)
      next_op = OP_XORF;
    else if (w[15:2] == 14'h0003)
      next_op = OP_TABLE_STORE;
  end

  // File operand addressing
  assign fileOfs  = ir[7:0];
  always_comb
  begin
    if (ir[8])
      fileAddr = {bank[3:0], fileOfs};
    else if (extEn && (fileOfs <= `CPUXE_ACCESS_LIMIT))
      fileAddr = 12'(ptr[2] + {4'h0, fileOfs});
    else if (fileOfs <= `CPUXE_ACCESS_LIMIT)
      fileAddr = {4'h0, fileOfs};
    else
      fileAddr = {`CPUXE_SFR_PAGE, fileOfs};
  end
  assign fileVal = mem[fileAddr];
  assign xorRes  = acc ^ ((op == OP_XORI) ? ir[7:0] : fileVal);
  assign moveSrc = 12'(ptr[2] + {5'h00, firstWord[6:0]});
  assign moveDst = (op == OP_MOVE_TO_FILE) ? ir[11:0] : 12'(ptr[2] + {5'h00, ir[6:0]});

  // Data memory write selection
  always_comb
  begin
    memWe = 1'b0;
    memWa = moveDst;
    memWd = mem[moveSrc];
    case (op)
      OP_XORF:
      begin
        memWe = ir[9];
        memWa = fileAddr;
        memWd = xorRes;
      end
      OP_MOVE_TO_FILE,
      OP_MOVE_TO_OFS: memWe = 1'b1;
      OP_LIT_PUSH:
      begin
        memWe = 1'b1;
        memWa = ptr[2];
        memWd = ir[7:0];
      end
      default: memWe = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (busWr && (address == `CPUXE_OFS_MEMDATA) && byteenable[0])
      mem[memAddr] <= writedata[7:0];
    else if (done && memWe)
      mem[memWa] <= memWd;
  end

  // Sequencer: four clock phases per instruction cycle
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      state    <= ST_IDLE;
      op       <= OP_NOP;
      ir       <= 16'h0000;
      clkCount <= 4'h0;
    end
    else
      case (state)
        ST_IDLE:
          if (write && (address == `CPUXE_OFS_INSTR))
          begin
            state    <= ST_EXEC;
            op       <= next_op;
            ir       <= w;
            clkCount <= 4'(cpuxe_cycles(next_op) * `CPUXE_Q_PER_CYCLE - 1);
          end
        ST_EXEC:
          if (clkCount == 4'h0)
            state <= ST_DONE;
          else
            clkCount <= clkCount - 4'h1;
        ST_DONE: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
  end

  // Skip and two-word tracking
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      skipPending  <= 1'b0;
      skipSecond   <= 1'b0;
      firstPending <= 1'b0;
      firstWord    <= 16'h0000;
    end
    else if (done)
    begin
      firstPending <= (op == OP_FIRST);
      if (op == OP_FIRST)
        firstWord <= ir;
      if (skipPending)
      begin
        skipPending <= 1'b0;
        skipSecond  <= cpuxe_two_word(ir);
      end
      else if (skipSecond)
        skipSecond <= 1'b0;
      else
        skipPending <= (op == OP_ZTEST) && (fileVal == 8'h00);
    end
  end

  // Accumulator, flags and bank select
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      acc   <= `CPUXE_RST_BYTE;
      flagN <= 1'b0;
      flagZ <= 1'b0;
      bank  <= `CPUXE_RST_BYTE;
    end
    else if (busWr)
    begin
      if (address == `CPUXE_OFS_ACC)
        acc <= 8'(merge({24'h0, acc}));
      if ((address == `CPUXE_OFS_STATUS) && byteenable[0])
      begin
        flagN <= writedata[`CPUXE_BIT_N];
        flagZ <= writedata[`CPUXE_BIT_Z];
      end
      if (address == `CPUXE_OFS_BANK)
        bank <= 8'(merge({24'h0, bank}));
    end
    else if (done && ((op == OP_XORI) || (op == OP_XORF)))
    begin
      if ((op == OP_XORI) || !ir[9])
        acc <= xorRes;
      flagN <= xorRes[7];
      flagZ <= (xorRes == 8'h00);
    end
  end

  // File select pointers
  assign ptrSel = (isRet || (op == OP_LIT_PUSH)) ? 2'd2 : ir[7:6];
  always_comb
  begin
    if (op == OP_LIT_PUSH)
      ptrNew = ptr[2] - 12'h001;
    else if ((op == OP_PSUB) || (op == OP_PSUBRET))
      ptrNew = ptr[ptrSel] - {6'h00, ir[5:0]};
    else
      ptrNew = ptr[ptrSel] + {6'h00, ir[5:0]};
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      for (int i = 0; i < 3; i++)
        ptr[i] <= `CPUXE_RST_PTR;
    else
      for (int i = 0; i < 3; i++)
        if (busWr && (address == 8'(`CPUXE_OFS_PTR0 + 4 * i)))
          ptr[i] <= 12'(merge({20'h0, ptr[i]}));
        else if (done && (ptrSel == 2'(i)) && (isRet || (op == OP_LIT_PUSH) || (op == OP_PADD) || (op == OP_PSUB)))
          ptr[i] <= ptrNew;
  end

  // Program counter, latches and return stack
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      pc         <= `CPUXE_RST_PC;
      sp         <= '0;
      highLatch  <= `CPUXE_RST_BYTE;
      upperLatch <= 5'h00;
    end
    else if (busWr)
    begin
      if (address == `CPUXE_OFS_PC)
        pc <= 21'(merge({11'h0, pc}));
      if (address == `CPUXE_OFS_HIGHLATCH)
        highLatch <= 8'(merge({24'h0, highLatch}));
      if (address == `CPUXE_OFS_UPPERLATCH)
        upperLatch <= 5'(merge({27'h0, upperLatch}));
    end
    else if (done)
    begin
      if (op == OP_CALL_ACC)
      begin
        if (sp < SPW'(STACK_DEPTH))
        begin
          stack[sp] <= 21'(pc + `CPUXE_PC_STEP);
          sp        <= sp + 1'b1;
        end
        pc <= {upperLatch, highLatch, acc};
      end
      else if (isRet && (sp != '0))
      begin
        pc <= stack[sp - 1'b1];
        sp <= sp - 1'b1;
      end
      else
        pc <= 21'(pc + `CPUXE_PC_STEP);
    end
  end

  // Table pointer, latch and holding registers
  assign tblNext = (ir[1:0] == 2'd2) ? 21'(table_pointer - 21'h1) : 21'(table_pointer + 21'h1);
  assign tblUse  = (ir[1:0] == 2'd3) ? tblNext : table_pointer;
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      table_pointer   <= `CPUXE_RST_PC;
      tabLatch <= `CPUXE_RST_BYTE;
      memAddr  <= `CPUXE_RST_PTR;
      for (int i = 0; i < 8; i++)
        hold[i] <= `CPUXE_RST_HOLD;
    end
    else if (busWr)
    begin
      if (address == `CPUXE_OFS_TBL_PTR)
        table_pointer <= 21'(merge({11'h0, table_pointer}));
      if (address == `CPUXE_OFS_TBL_LATCH)
        tabLatch <= 8'(merge({24'h0, tabLatch}));
      if (address == `CPUXE_OFS_MEMADDR)
        memAddr <= 12'(merge({20'h0, memAddr}));
    end
    else if (done && (op == OP_TABLE_STORE))
    begin
      hold[tblUse[2:0]] <= tabLatch;
      if (ir[1:0] != 2'd0)
        table_pointer <= tblNext;
    end
  end

  // Instruction cycle counter
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      cycleCount <= 32'h0000_0000;
    else if (done)
      cycleCount <= cycleCount + {30'h0, cpuxe_cycles(op)};
  end

  // Register read multiplexer
  always_comb
  begin
    rdMux = 32'h0000_0000;
    case (address)
      `CPUXE_OFS_INSTR:      rdMux = {16'h0, ir};
      `CPUXE_OFS_ACC:        rdMux = {24'h0, acc};
      `CPUXE_OFS_STATUS:     rdMux = {26'h0, extEn, firstPending, skipSecond, skipPending, flagN, flagZ};
      `CPUXE_OFS_BANK:       rdMux = {24'h0, bank};
      `CPUXE_OFS_PTR0:       rdMux = {20'h0, ptr[0]};
      `CPUXE_OFS_PTR1:       rdMux = {20'h0, ptr[1]};
      `CPUXE_OFS_PTR2:       rdMux = {20'h0, ptr[2]};
      `CPUXE_OFS_PC:         rdMux = {11'h0, pc};
      `CPUXE_OFS_HIGHLATCH:  rdMux = {24'h0, highLatch};
      `CPUXE_OFS_UPPERLATCH: rdMux = {27'h0, upperLatch};
      `CPUXE_OFS_TBL_PTR:    rdMux = {11'h0, table_pointer};
      `CPUXE_OFS_TBL_LATCH:  rdMux = {24'h0, tabLatch};
      `CPUXE_OFS_MEMADDR:    rdMux = {20'h0, memAddr};
      `CPUXE_OFS_MEMDATA:    rdMux = {24'h0, mem[memAddr]};
      `CPUXE_OFS_CYCLES:     rdMux = cycleCount;
      `CPUXE_OFS_HOLD:       rdMux = {24'h0, hold[memAddr[2:0]]};
      `CPUXE_OFS_STACK:      rdMux = {3'h0, 8'(sp), (sp != '0) ? stack[sp - 1'b1] : 21'h0};
      default:               rdMux = 32'h0000_0000;
    endcase
  end

  // Reads answer one cycle after the request
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      rdValid  <= 1'b0;
      readdata <= 32'h0000_0000;
    end
    else
    begin
      rdValid <= read && !rdValid;
      if (read && !rdValid)
        readdata <= rdMux;
    end
  end

  // Stall reads one cycle and instruction issue until execution ends
  assign waitrequest = (read && !rdValid) || (write && (address == `CPUXE_OFS_INSTR) && !done);
endmodule
`default_nettype wire

// ===== verilog/cpuxe_params.svh
// Register offsets, field positions, reset values and timing counts of the execution unit
`ifndef CPUXE_PARAMS_SVH
`define CPUXE_PARAMS_SVH
`define CPUXE_OFS_INSTR      8'h00
`define CPUXE_OFS_ACC        8'h04
`define CPUXE_OFS_STATUS     8'h08
`define CPUXE_OFS_BANK       8'h0C
`define CPUXE_OFS_PTR0       8'h10
`define CPUXE_OFS_PTR1       8'h14
`define CPUXE_OFS_PTR2       8'h18
`define CPUXE_OFS_PC         8'h1C
`define CPUXE_OFS_HIGHLATCH  8'h20
`define CPUXE_OFS_UPPERLATCH 8'h24
`define CPUXE_OFS_TBL_PTR    8'h28
`define CPUXE_OFS_TBL_LATCH  8'h2C
`define CPUXE_OFS_MEMADDR    8'h30
`define CPUXE_OFS_MEMDATA    8'h34
`define CPUXE_OFS_CYCLES     8'h38
`define CPUXE_OFS_HOLD       8'h3C
`define CPUXE_OFS_STACK      8'h40
`define CPUXE_BIT_Z          0
`define CPUXE_BIT_N          1
`define CPUXE_BIT_SKIP       2
`define CPUXE_BIT_SKIP2      3
`define CPUXE_BIT_FIRST      4
`define CPUXE_BIT_EXT        5
`define CPUXE_ACCESS_LIMIT   8'h5F
`define CPUXE_SFR_PAGE       4'hF
`define CPUXE_CALL_ACC_CODE  16'h0014
`define CPUXE_PC_STEP        21'h000002
`define CPUXE_RST_BYTE       8'h00
`define CPUXE_RST_PTR        12'h000
`define CPUXE_RST_PC         21'h000000
`define CPUXE_RST_HOLD       8'hFF
`define CPUXE_Q_PER_CYCLE    4
`define CPUXE_MEM_WORDS      4096
`endif

// ===== verilog/cpuxe_pkg.sv
// Types and decode helpers of the execution unit
`default_nettype none
package cpuxe_pkg;
  typedef enum {ST_IDLE, ST_EXEC, ST_DONE} cpuxe_state_e;
  typedef enum {OP_NOP, OP_ZTEST, OP_XORI, OP_XORF, OP_PADD, OP_PSUB, OP_PADDRET, OP_PSUBRET,
                OP_CALL_ACC, OP_FIRST, OP_MOVE_TO_FILE, OP_MOVE_TO_OFS, OP_LIT_PUSH, OP_TABLE_STORE} cpuxe_op_e;

  // Instruction cycles taken by one issued word
  function automatic logic [1:0] cpuxe_cycles(input cpuxe_op_e op);
    case (op)
      OP_PADDRET,
      OP_PSUBRET,
      OP_CALL_ACC,
      OP_TABLE_STORE: cpuxe_cycles = 2'd2;
      default:  cpuxe_cycles = 2'd1;
    endcase
  endfunction

  // First words of the two-word instructions
  function automatic logic cpuxe_two_word(input logic [15:0] w);
    cpuxe_two_word = (w[15:12] == 4'hC) || (w[15:9] == 7'b1110110) || (w[15:8] == 8'hEF)
                     || (w[15:6] == 10'b1110111000) || (w[15:8] == 8'hEB);
  endfunction
endpackage
`default_nettype wire

// ===== verif/cpuxe_core_asserts.sv
// Port-level timing and status checks of the execution unit
`timescale 1ns/100ps
`default_nettype none
`include "cpuxe_params.svh"
module cpuxe_chk #(
  parameter int STACK_DEPTH = 31
)
(
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        extensionEnableCfg,
  input wire logic [7:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest
);
  logic [3:0] waitCnt;
  logic       cfgSeen;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Wait cycles of the instruction write in progress
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n || !(write && address == 8'h00 && waitrequest))
      waitCnt <= 4'h0;
    else
      waitCnt <= waitCnt + 4'h1;
  end
  // Configuration level seen while reset is held
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      cfgSeen <= extensionEnableCfg;
  end
  a_read_first_wait: assert property ($rose(read) |-> waitrequest)
    else $error("read answered without a wait");
  a_read_one_wait: assert property (read && waitrequest |=> !waitrequest)
    else $error("read wait longer than one cycle");
  a_idle_no_wait: assert property (!read && !write |-> !waitrequest)
    else $error("wait raised with no request");
  a_write_no_wait: assert property (write && address != 8'h00 |-> !waitrequest)
    else $error("register write delayed");
  a_xor_imm_time: assert property ($rose(write) && address == 8'h00 && writedata[15:8] == 8'h0A
    |-> waitrequest [*5] ##1 !waitrequest)
    else $error("immediate exclusive-OR not one instruction cycle");
  a_instr_cycle_count: assert property (write && address == 8'h00 && !waitrequest
    |-> waitCnt == 4'h5 || waitCnt == 4'h9)
    else $error("instruction length not one or two cycles");
  a_unmapped_zero: assert property (read && !waitrequest && address == 8'hFC |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  a_ext_status_bit: assert property (read && !waitrequest && address == `CPUXE_OFS_STATUS
    |-> readdata[`CPUXE_BIT_EXT] == cfgSeen)
    else $error("extension status differs from configuration");
  a_data_held: assert property (!read |=> $stable(readdata))
    else $error("read data changed without a read");
  c_xor_imm: cover property (write && address == 8'h00 && writedata[15:8] == 8'h0A && !waitrequest);
  c_two_cycle: cover property (write && address == 8'h00 && !waitrequest && waitCnt == 4'h9);
  c_unmapped: cover property (read && !waitrequest && address == 8'hFC);
endmodule
bind cpuxe_core cpuxe_chk #(.STACK_DEPTH(STACK_DEPTH)) u_chk (.ref_clk, .reset_n, .extensionEnableCfg,
  .address, .read, .write, .byteenable, .writedata, .readdata, .waitrequest);
`default_nettype wire

// ===== verif/cpuxe_core_tb_top.sv
// Self-checking bench of the execution unit through its register bus
`timescale 1ns/100ps
`default_nettype none
`include "cpuxe_params.svh"
module cpuxe_core_tb_top;
  localparam logic [7:0] AC = `CPUXE_OFS_ACC, ST = `CPUXE_OFS_STATUS, P2 = 8'h18, PC = `CPUXE_OFS_PC;
  localparam logic [7:0] MA = `CPUXE_OFS_MEMADDR, MD = `CPUXE_OFS_MEMDATA, HD = `CPUXE_OFS_HOLD;
  localparam logic [7:0] TP = `CPUXE_OFS_TBL_PTR, TL = `CPUXE_OFS_TBL_LATCH, SK = `CPUXE_OFS_STACK;
  logic        ref_clk;
  logic        reset_n;
  logic        extensionEnableCfg;
  logic [7:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [31:0] qExp[$];
  logic [31:0] qMask[$];
  logic [7:0]  qAdr[$];
  logic [31:0] seed;
  logic [31:0] tmp;
  logic [20:0] expPc;
  logic [20:0] ret;
  logic [15:0] expCyc;
  logic [7:0]  a;
  logic [7:0]  k;
  logic        d;
  logic [8:0]  af[3] = '{9'h133, 9'h0A0, 9'h010};
  logic [11:0] ea[3] = '{12'h533, 12'hFA0, 12'h133};
  int          numErrors;
  int          nChecks;
  int          cycles;
  cpuxe_core dut (.ref_clk, .reset_n, .extensionEnableCfg, .address, .read, .write, .byteenable(4'hF),
                  .writedata, .readdata, .waitrequest);
  // Clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Hang guard
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      numErrors++;
      tallyAndFinish();
    end
  end
  // Answer watcher against the oldest note
  always @(negedge ref_clk)
  begin
    if (reset_n && read && !waitrequest)
      chk(qAdr.pop_front(), readdata & qMask.pop_front(), qExp.pop_front());
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [7:0] ad, input logic [31:0] s, input logic [31:0] e);
    nChecks++;
    if (s !== e)
    begin
      numErrors++;
      $display("unexpected register %h: expected %h seen %h", ad, e, s);
    end
  endtask
  task automatic tallyAndFinish();
    if (numErrors == 0 && nChecks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic xfer(input logic r, input logic [7:0] ad, input logic [31:0] dt);
    address   <= ad;
    writedata <= dt;
    read      <= r;
    write     <= !r;
    do @(posedge ref_clk); while (waitrequest !== 1'b0);
    read  <= 1'b0;
    write <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    xfer(1'b0, ad, dt);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] m);
    qAdr.push_back(ad);
    qExp.push_back(e & m);
    qMask.push_back(m);
    xfer(1'b1, ad, 32'h0);
  endtask
  task automatic issue(input logic [15:0] w, input logic [15:0] c);
    wr(`CPUXE_OFS_INSTR, {16'h0, w});
    expPc += 21'h2;
    expCyc += c;
  endtask
  task automatic wm(input logic [11:0] ad, input logic [7:0] v);
    wr(MA, {20'h0, ad});
    wr(MD, {24'h0, v});
  endtask
  task automatic rm(input logic [11:0] ad, input logic [7:0] v);
    wr(MA, {20'h0, ad});
    rd(MD, {24'h0, v}, 32'hFF);
  endtask
  task automatic progress();
    rd(PC, {11'h0, expPc}, 32'h1FFFFF);
    rd(`CPUXE_OFS_CYCLES, {16'h0, expCyc}, 32'hFFFF);
  endtask
  task automatic rst(input logic cfg);
    extensionEnableCfg <= cfg;
    reset_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    expPc = 21'h0;
    expCyc = 16'h0;
  endtask
  // Main sequence
  initial
  begin
    seed = 32'd86851;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    writedata = 32'h0;
    cycles = 0;
    rst(1'b1);
    rd(ST, 32'h20, 32'h3F);
    rd(8'hFC, 32'h0, 32'hFFFFFFFF);
    for (int i = 0; i < 6; i++)
    begin
      tmp = rnd();
      a = tmp[7:0];
      k = (i == 0) ? a : tmp[15:8];
      wr(AC, {24'h0, a});
      issue({8'h0A, k}, 16'h1);
      rd(AC, {24'h0, a ^ k}, 32'hFF);
      rd(ST, {30'h0, a[7] ^ k[7], (a ^ k) == 8'h00}, 32'h3);
    end
    wr(`CPUXE_OFS_BANK, 32'h05);
    wr(P2, 32'h123);
    for (int i = 0; i < 6; i++)
    begin
      tmp = rnd();
      a = tmp[7:0];
      k = tmp[15:8];
      d = (i >= 3);
      wr(AC, {24'h0, a});
      wm(ea[i % 3], k);
      issue({6'b000110, d, af[i % 3]}, 16'h1);
      rd(AC, {24'h0, d ? a : a ^ k}, 32'hFF);
      rm(ea[i % 3], d ? a ^ k : k);
      rd(ST, {30'h0, a[7] ^ k[7], (a ^ k) == 8'h00}, 32'h3);
    end
    wr(AC, 32'h11);
    wm(12'h533, 8'h00);
    wm(12'h456, 8'h77);
    issue(16'h6733, 16'h1);
    issue(16'h0AFF, 16'h1);
    rd(AC, 32'h11, 32'hFF);
    issue(16'h6733, 16'h1);
    issue(16'hEB05, 16'h1);
    issue(16'hF456, 16'h1);
    issue(16'h0A01, 16'h1);
    rm(12'h456, 8'h77);
    wm(12'h533, 8'h5A);
    issue(16'h6733, 16'h1);
    issue(16'h0A0F, 16'h1);
    rd(AC, 32'h1F, 32'hFF);
    progress();
    wr(ST, 32'h3);
    for (int f = 0; f < 3; f++)
    begin
      wr(8'h10 + 8'(4 * f), 32'h3FF);
      issue({8'hE8, 2'(f), 6'h23}, 16'h1);
      rd(8'h10 + 8'(4 * f), 32'h422, 32'hFFF);
      issue({8'hE9, 2'(f), 6'h3F}, 16'h1);
      rd(8'h10 + 8'(4 * f), 32'h3E3, 32'hFFF);
    end
    rd(ST, 32'h3, 32'h3);
    wr(AC, 32'h40);
    wr(`CPUXE_OFS_HIGHLATCH, 32'h12);
    wr(`CPUXE_OFS_UPPERLATCH, 32'h03);
    issue(16'h0014, 16'h2);
    ret = expPc;
    expPc = 21'h031240;
    rd(SK, {3'h0, 8'h01, ret}, 32'h1FFFFFFF);
    progress();
    rd(ST, 32'h3, 32'h3);
    wr(P2, 32'h3FF);
    issue(16'hE8E3, 16'h2);
    expPc = ret;
    rd(P2, 32'h422, 32'hFFF);
    issue(16'hE9C2, 16'h2);
    rd(P2, 32'h420, 32'hFFF);
    progress();
    wr(P2, 32'h200);
    issue(16'hEA55, 16'h1);
    rm(12'h200, 8'h55);
    rd(P2, 32'h1FF, 32'hFFF);
    wm(12'h204, 8'h3C);
    issue(16'hEB05, 16'h1);
    issue(16'hF456, 16'h1);
    rm(12'h456, 8'h3C);
    issue(16'hEB85, 16'h1);
    issue(16'hF007, 16'h1);
    rm(12'h206, 8'h3C);
    wr(MA, 32'h6);
    rd(HD, 32'hFF, 32'hFF);
    wr(TP, 32'hA356);
    wr(TL, 32'h55);
    issue(16'h000D, 16'h2);
    rd(HD, 32'h55, 32'hFF);
    rd(TP, 32'hA357, 32'h1FFFFF);
    wr(TP, 32'h1389A);
    wr(TL, 32'h34);
    issue(16'h000F, 16'h2);
    rd(TP, 32'h1389B, 32'h1FFFFF);
    wr(MA, 32'h3);
    rd(HD, 32'h34, 32'hFF);
    wr(MA, 32'h2);
    rd(HD, 32'hFF, 32'hFF);
    wr(TL, 32'h66);
    issue(16'h000E, 16'h2);
    rd(TP, 32'h1389A, 32'h1FFFFF);
    issue(16'h000C, 16'h2);
    rd(TP, 32'h1389A, 32'h1FFFFF);
    rd(HD, 32'h66, 32'hFF);
    progress();
    rst(1'b0);
    rd(ST, 32'h0, 32'h20);
    wr(8'h10, 32'h100);
    issue(16'hE805, 16'h1);
    rd(8'h10, 32'h100, 32'hFFF);
    issue(16'h0014, 16'h1);
    progress();
    wm(12'h010, 8'h0F);
    wr(AC, 32'hF0);
    issue(16'h1A10, 16'h1);
    rm(12'h010, 8'hFF);
    tallyAndFinish();
  end
endmodule
`default_nettype wire
